// file: rtl/pulse_counter_map.svh
`ifndef PULSE_COUNTER_MAP_SVH
`define PULSE_COUNTER_MAP_SVH

// Register byte offsets
`define OFS_CTRL      8'h00
`define OFS_SEL       8'h04
`define OFS_EDGE      8'h08
`define OFS_START     8'h0c
`define OFS_WORK      8'h10
`define OFS_HOLD      8'h14
`define OFS_DIR       8'h18
`define OFS_PDATA     8'h1c
`define OFS_HIDDEN    8'h20
`define OFS_LEVELS    8'h24
`define OFS_STATUS    8'h28

// Field positions
`define CTRL_START_BIT  31
`define CTRL_RUN_BIT    8
`define HIDDEN_DUMMY_LSB 16

// Pin selector spaces
`define SEL_REAL_LAST    7'h20
`define SEL_HIDDEN_FIRST 7'h21
`define SEL_DUMMY_FIRST  7'h31
`define SEL_LAST         7'h40

// Counter values and reset values
`define WORK_FINAL    16'hffff
`define WORK_ZERO     16'h0000
`define WORK_ONE      16'h0001
`define RST_WORD      32'h0000_0000
`define RST_DIR       4'h0

`endif

// file: rtl/pulse_counter_pkg.sv
package pulse_counter_pkg;

	// Function codes as the host writes them
	typedef enum logic [6:0] {
		mode_off             = 7'h00,
		updown_sample_mode   = 7'h06,
		quadrature_mode      = 7'h07,
		freerun_sample_mode  = 7'h08,
		freerun_sample_dn    = 7'h6c,
		interval_sample_mode = 7'h09,
		interval_sample_dn   = 7'h6d,
		freerun_compare_mode = 7'h0a,
		freerun_compare_dn   = 7'h6e
	} mode_t;

	typedef enum logic [1:0] {
		st_idle = 2'b01,
		st_run  = 2'b10
	} run_state_t;

	// Pin selectors, 0..64 each
	typedef struct packed {
		logic [6:0] direction_gate;
		logic [6:0] sample_strobe;
		logic [6:0] count_source;
		logic [6:0] result_line;
	} pin_sel_t;

	// Edge codes: bit 0 rising, bit 1 falling
	typedef struct packed {
		logic       polarity;
		logic [1:0] strobe_edge;
		logic [1:0] count_edge;
	} edge_cfg_t;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
	} ahb_req_t;

endpackage : pulse_counter_pkg

// file: rtl/multimode_pulse_counter.sv
`timescale 1ns/1ps
`include "pulse_counter_map.svh"
module multimode_pulse_counter
	import pulse_counter_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [31:0] pin_in,
	output logic      [31:0] pin_out,
	output logic      [31:0] pin_oe_b,
	output logic             result_line
);

	////////////////////////////////////////////////////////////////////
	// Declarations
	ahb_req_t   req_q;
	pin_sel_t   sel_q;
	edge_cfg_t  edge_q;
	mode_t      mode_q, mode_d;
	run_state_t state_q;
	logic [15:0] start_value_q, work_q, work_d, hold_q, hold_d;
	logic [3:0]  dir_q;
	logic [31:0] pdata_q, pin_s1_q, pin_s2_q, real_lvl;
	logic [31:0] pin_out_d, pin_oe_d;
	logic [15:0] hidden_q, hidden_d, dummy_q, dummy_d;
	logic [64:0] all_pins;
	logic        res_d, addr_ok, wr_ctrl, start_w;
	logic        cnt_lvl, strb_lvl, gate_lvl, cnt_prev_q, strb_prev_q;
	logic        cnt_ev, strb_ev, cnt_rise, cnt_fall, strb_rise, strb_fall;
	logic        step_up, ovf, q_inc, q_dec, running;
	logic [31:0] rd_mux;

	// Level of one selected pin; out-of-range selectors read low
	function automatic logic pick(input logic [64:0] v, input logic [6:0] s);
		logic r;
		r = 1'b0;
		if (s <= `SEL_LAST)
			r = v[s];
		return r;
	endfunction : pick

	////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states, always OKAY
	assign addr_ok = hsel & htrans[1] & hready;
	assign wr_ctrl = req_q.wr && req_q.addr == `OFS_CTRL;
	assign start_w = wr_ctrl & hwdata[`CTRL_START_BIT];

	// Address phase latch; hsize ignored since only words are mapped
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			req_q <= '0;
		end else begin
			req_q.wr   <= addr_ok & hwrite;
			req_q.addr <= haddr[7:0];
		end
	end

	// Read data selected in the address phase so hrdata is a flop
	always_comb begin
		rd_mux = `RST_WORD;
		case (haddr[7:0])
			`OFS_CTRL:   rd_mux = {23'h000000, running, 1'b0, mode_q};
			`OFS_SEL:    rd_mux = {1'b0, sel_q.direction_gate, 1'b0,
				sel_q.sample_strobe, 1'b0, sel_q.count_source, 1'b0,
				sel_q.result_line};
			`OFS_EDGE:   rd_mux = {27'h0000000, edge_q};
			`OFS_START:  rd_mux = {16'h0000, start_value_q};
			`OFS_WORK:   rd_mux = {16'h0000, work_q};
			`OFS_HOLD:   rd_mux = {16'h0000, hold_q};
			`OFS_DIR:    rd_mux = {28'h0000000, dir_q};
			`OFS_PDATA:  rd_mux = pdata_q;
			`OFS_HIDDEN: rd_mux = {dummy_q, hidden_q};
			`OFS_LEVELS: rd_mux = real_lvl;
			`OFS_STATUS: rd_mux = {31'h00000000, result_line};
			default:     rd_mux = `RST_WORD; // Unmapped reads as zero
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hrdata    <= `RST_WORD;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (addr_ok && !hwrite)
				hrdata <= rd_mux;
		end
	end

	// Configuration registers written in the data phase
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_q         <= '0;
			edge_q        <= '0;
			start_value_q <= `WORK_ZERO;
			dir_q         <= `RST_DIR;
			pdata_q       <= `RST_WORD;
		end else if (req_q.wr) begin
			case (req_q.addr)
				`OFS_SEL: sel_q <= {hwdata[30:24], hwdata[22:16],
					hwdata[14:8], hwdata[6:0]};
				`OFS_EDGE:  edge_q        <= hwdata[4:0];
				`OFS_START: start_value_q <= hwdata[15:0];
				`OFS_DIR:   dir_q         <= hwdata[3:0];
				`OFS_PDATA: pdata_q       <= hwdata;
				default: ;
			endcase
		end
	end

	// Unsupported codes fall back to off so nothing counts
	always_comb begin
		mode_d = mode_off;
		case (hwdata[6:0])
			7'h06, 7'h07, 7'h08, 7'h6c, 7'h09, 7'h6d, 7'h0a, 7'h6e:
				mode_d = mode_t'(hwdata[6:0]);
			default: mode_d = mode_off;
		endcase
	end

	// Run control: writing without the start bit stops the channel
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q  <= mode_off;
			state_q <= st_idle;
		end else if (wr_ctrl) begin
			mode_q <= mode_d;
			unique case (state_q)
				st_idle: if (start_w && mode_d != mode_off) state_q <= st_run;
				st_run:  if (!start_w || mode_d == mode_off) state_q <= st_idle;
			endcase
		end
	end
	assign running = state_q == st_run;

	////////////////////////////////////////////////////////////////////
	// Pin spaces and input synchroniser
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_q <= `RST_WORD;
			pin_s2_q <= `RST_WORD;
		end else begin
			pin_s1_q <= pin_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Driven real pins read back their own level, others the sync'd pad
	assign real_lvl = (pin_oe_b & pin_s2_q) | (~pin_oe_b & pin_out);
	assign all_pins = {dummy_q, hidden_q, real_lvl, 1'b0};

	// Per real pin: result routing and direction
	for (genvar i = 0; i < 32; i++) begin : g_real
		localparam int GRP = (i < 16) ? i / 4 : 2 + (i - 16) / 4;
		assign pin_out_d[i] = (sel_q.result_line == 7'(i + 1)) ?
			result_line : pdata_q[i];
		if ((i % 16) >= 8) begin : g_fixed
			assign pin_oe_d[i] = 1'b0; // Always driven
		end else begin : g_grp
			assign pin_oe_d[i] = ~dir_q[GRP]; // Groups of four
		end
	end

	// Hidden pins take the result or software; dummy only the result
	for (genvar j = 0; j < 16; j++) begin : g_internal
		assign hidden_d[j] =
			(sel_q.result_line == 7'(j) + `SEL_HIDDEN_FIRST) ? result_line :
			(req_q.wr && req_q.addr == `OFS_HIDDEN) ? hwdata[j] :
			hidden_q[j];
		assign dummy_d[j] =
			(sel_q.result_line == 7'(j) + `SEL_DUMMY_FIRST) ? result_line :
			dummy_q[j];
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_out  <= `RST_WORD;
			pin_oe_b <= 32'hffff_ffff;
			hidden_q <= `WORK_ZERO;
			dummy_q  <= `WORK_ZERO;
		end else begin
			pin_out  <= pin_out_d;
			pin_oe_b <= pin_oe_d;
			hidden_q <= hidden_d;
			dummy_q  <= dummy_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Event detection on the selected count and strobe lines; the gate line is used as a level
	assign cnt_lvl  = pick(all_pins, sel_q.count_source);
	assign strb_lvl = pick(all_pins, sel_q.sample_strobe);
	assign gate_lvl = pick(all_pins, sel_q.direction_gate);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_prev_q  <= 1'b0;
			strb_prev_q <= 1'b0;
		end else begin
			cnt_prev_q  <= cnt_lvl;
			strb_prev_q <= strb_lvl;
		end
	end

	assign cnt_rise  = cnt_lvl & ~cnt_prev_q;
	assign cnt_fall  = ~cnt_lvl & cnt_prev_q;
	assign strb_rise = strb_lvl & ~strb_prev_q;
	assign strb_fall = ~strb_lvl & strb_prev_q;
	// Selector 0 on the count line means every clock cycle
	assign cnt_ev = (sel_q.count_source == 7'h00) ? 1'b1 :
		(edge_q.count_edge[0] & cnt_rise) |
		(edge_q.count_edge[1] & cnt_fall);
	// Selector 0 on the strobe line means no strobe at all
	assign strb_ev = (sel_q.sample_strobe != 7'h00) &
		((edge_q.strobe_edge[0] & strb_rise) |
		(edge_q.strobe_edge[1] & strb_fall));

	// Quadrature: a change on both lines in one cycle is ambiguous, dropped
	assign q_inc = ((cnt_rise & ~strb_lvl & ~strb_rise & ~strb_fall) |
		(strb_rise & ~cnt_lvl & ~cnt_rise & ~cnt_fall));
	assign q_dec = ((cnt_fall & ~strb_lvl & ~strb_rise & ~strb_fall) |
		(strb_fall & ~cnt_lvl & ~cnt_rise & ~cnt_fall));

	// Direction: gate against polarity, or the code's hundreds flag
	assign step_up = (mode_q == updown_sample_mode) ?
		(gate_lvl ^ edge_q.polarity) : ~mode_q[6];
	assign ovf = cnt_ev & (step_up ? work_q == `WORK_FINAL :
		work_q == `WORK_ZERO);

	////////////////////////////////////////////////////////////////////
	// Counter core
	always_comb begin
		work_d = work_q;
		hold_d = hold_q;
		res_d  = result_line;
		if (start_w) begin
			work_d = start_value_q;
			if (mode_d != quadrature_mode)
				hold_d = start_value_q;
			res_d = 1'b0;
		end else if (running) begin
			if (cnt_ev && mode_q != quadrature_mode)
				work_d = step_up ? work_q + `WORK_ONE :
					work_q - `WORK_ONE;
			unique case (mode_q)
				updown_sample_mode: begin
					if (strb_ev)
						hold_d = work_q;
					res_d = work_d == `WORK_FINAL;
				end
				quadrature_mode: begin
					if (q_inc && edge_q.count_edge != 2'b00)
						work_d = work_q + `WORK_ONE;
					else if (q_dec && edge_q.strobe_edge != 2'b00)
						work_d = work_q - `WORK_ONE;
				end
				freerun_sample_mode, freerun_sample_dn: begin
					if (strb_ev)
						hold_d = work_q;
					if (ovf)
						res_d = 1'b1;
				end
				interval_sample_mode, interval_sample_dn: begin
					if (strb_ev) begin
						hold_d = work_q;
						work_d = `WORK_ZERO; // Clear beats a count
					end
					if (ovf)
						res_d = 1'b1;
				end
				freerun_compare_mode, freerun_compare_dn:
					res_d = work_d >= hold_q;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			work_q      <= `WORK_ZERO;
			hold_q      <= `WORK_ZERO;
			result_line <= 1'b0;
		end else begin
			work_q      <= work_d;
			hold_q      <= hold_d;
			result_line <= res_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	property p_uds_step;
		@(posedge clk) disable iff (!rst_b)
		(running && mode_q == updown_sample_mode && cnt_ev && !start_w)
		|=> (work_q - $past(work_q)) ==
			($past(gate_lvl ^ edge_q.polarity) ? 16'h0001 : 16'hffff);
	endproperty
	a_uds_step: assert property (p_uds_step)
		else $error("up/down step direction wrong");

	property p_uds_sample;
		@(posedge clk) disable iff (!rst_b)
		(running && mode_q == updown_sample_mode && strb_ev && !start_w)
		|=> hold_q == $past(work_q);
	endproperty
	a_uds_sample: assert property (p_uds_sample)
		else $error("up/down sample not taken");

	property p_uds_final;
		@(posedge clk) disable iff (!rst_b)
		(running && mode_q == updown_sample_mode && !start_w)
		##1 (mode_q == updown_sample_mode)
		|-> result_line == (work_q == 16'hffff);
	endproperty
	a_uds_final: assert property (p_uds_final)
		else $error("final value output wrong");

	property p_preload;
		@(posedge clk) disable iff (!rst_b)
		start_w |=> work_q == $past(start_value_q) && !result_line;
	endproperty
	a_preload: assert property (p_preload)
		else $error("start did not preload");

	property p_quad_hold;
		@(posedge clk) disable iff (!rst_b)
		(start_w && mode_d == quadrature_mode) |=> hold_q == $past(hold_q);
	endproperty
	a_quad_hold: assert property (p_quad_hold)
		else $error("quadrature start touched hold");

	property p_quad_inc;
		@(posedge clk) disable iff (!rst_b)
		(running && mode_q == quadrature_mode && q_inc && !start_w &&
			edge_q.count_edge != 2'b00) |=> work_q == $past(work_q) + 16'h1;
	endproperty
	a_quad_inc: assert property (p_quad_inc)
		else $error("quadrature increment missed");

	property p_ins_clear;
		@(posedge clk) disable iff (!rst_b)
		(running && mode_q == interval_sample_mode && strb_ev && !start_w)
		|=> work_q == 16'h0000 && hold_q == $past(work_q);
	endproperty
	a_ins_clear: assert property (p_ins_clear)
		else $error("interval sample did not clear");

	property p_ovf_sticky;
		@(posedge clk) disable iff (!rst_b)
		(running && ovf && !start_w && !wr_ctrl &&
			(mode_q == freerun_sample_mode || mode_q == interval_sample_dn))
		|=> result_line ##1 result_line;
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky)
		else $error("overflow output not held");

	property p_frc_cmp;
		@(posedge clk) disable iff (!rst_b)
		(running && mode_q == freerun_compare_mode && !wr_ctrl)
		|=> result_line == (work_q >= hold_q);
	endproperty
	a_frc_cmp: assert property (p_frc_cmp)
		else $error("compare output wrong");

	property p_wrap;
		@(posedge clk) disable iff (!rst_b)
		(running && mode_q == freerun_sample_mode && cnt_ev &&
			!start_w && work_q == 16'hffff) |=> work_q == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("counter did not wrap");

	property p_no_strobe;
		@(posedge clk) disable iff (!rst_b)
		(sel_q.sample_strobe == 7'h00 && !start_w)
		|=> hold_q == $past(hold_q);
	endproperty
	a_no_strobe: assert property (p_no_strobe)
		else $error("strobe seen with no strobe pin");

	property p_fixed_out;
		@(posedge clk) disable iff (!rst_b)
		rst_b |=>
			(pin_oe_b[15:8] == 8'h00 && pin_oe_b[31:24] == 8'h00);
	endproperty
	a_fixed_out: assert property (p_fixed_out)
		else $error("fixed output pins released");

endmodule : multimode_pulse_counter

// file: verification/pulse_source.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Far side: pads shared by the outside pulse sources and the device drivers
module pulse_source (
	input  wire logic [31:0] pin_out,
	input  wire logic [31:0] pin_oe_b,
	input  wire logic [31:0] ext,
	output logic      [31:0] pin_in
);
	logic [31:0] ext_ok;

	// Outside sources never reach the hardwired output pins
	assign ext_ok = ext & 32'h00ff_00ff;

	// Pad level: the device drive wins wherever it is enabled
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			pin_in[i] = pin_oe_b[i] ? ext_ok[i] : pin_out[i];
		end
	end
endmodule : pulse_source

// file: verification/tb_multimode_pulse_counter.sv
`timescale 1ns/1ps
`include "pulse_counter_map.svh"
module tb_multimode_pulse_counter
	import pulse_counter_pkg::*;
;
	logic        clk;
	logic        rst_b;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hready;
	logic [31:0] hrdata;
	logic        hresp;
	logic [31:0] pin_in;
	logic [31:0] pin_out;
	logic [31:0] pin_oe_b;
	logic        result_line;
	logic [31:0] ext;
	int          error_cnt;
	int          num_checks;
	int          cyc;

	multimode_pulse_counter i_multimode_pulse_counter (
		.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready),
		.hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_b(pin_oe_b), .result_line(result_line)
	);

	pulse_source i_pulse_source (
		.pin_out(pin_out), .pin_oe_b(pin_oe_b), .ext(ext), .pin_in(pin_in)
	);

	////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard; the whole run needs about 600 cycles
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			error_cnt++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One AHB-Lite single transfer; address held until hready is seen high
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] v);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		v = hrdata;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		xfer(1'b1, a, d, v);
	endtask : wr

	task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		xfer(1'b0, a, 32'h0000_0000, v);
		check(v, exp);
		check({31'h0, hresp}, 32'h0000_0000);
	endtask : expect_reg

	task automatic chk_res(input logic exp);
		check({31'h0, result_line}, {31'h0, exp});
	endtask : chk_res

	// Pad change, then enough cycles for sync, detect and update
	task automatic set_pin(input int i, input logic val);
		@(posedge clk);
		ext[i] <= val;
		repeat (6) @(posedge clk);
	endtask : set_pin

	task automatic pulse(input int i);
		set_pin(i, 1'b1);
		set_pin(i, 1'b0);
	endtask : pulse

	function automatic logic [31:0] mk_sel(input logic [6:0] g,
		input logic [6:0] s, input logic [6:0] c, input logic [6:0] r);
		return {1'b0, g, 1'b0, s, 1'b0, c, 1'b0, r};
	endfunction : mk_sel

	task automatic start(input mode_t m, input logic [31:0] sel,
		input edge_cfg_t e, input logic [15:0] sv);
		// One channel only; the map fixes slot and register indices
		wr(`OFS_START, {16'h0000, sv});
		wr(`OFS_EDGE, {27'h000_0000, e});
		wr(`OFS_SEL, sel);
		wr(`OFS_CTRL, {1'b1, 24'h00_0000, m});
	endtask : start

	////////////////////////////////////////////////////////////////////////////
	// Scenarios; pins 1, 2, 3 carry count, strobe, gate; pin 9 the result
	task automatic t_reset();
		expect_reg(`OFS_WORK, 32'h0000_0000);
		expect_reg(8'h3c, 32'h0000_0000);
		check(pin_oe_b & 32'hff00_ff00, 32'h0000_0000);
		wr(`OFS_DIR, 32'h0000_0001);
		// Direction flop first, then the registered pad enable
		repeat (2) @(posedge clk);
		check(pin_oe_b & 32'h0000_00ff, 32'h0000_00f0);
		wr(`OFS_DIR, 32'h0000_0000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_uds();
		start(updown_sample_mode, mk_sel(7'h03, 7'h02, 7'h01, 7'h09),
			5'h15, 16'hfffd);
		expect_reg(`OFS_HOLD, 32'h0000_fffd);
		pulse(0);
		pulse(0);
		expect_reg(`OFS_WORK, 32'h0000_ffff);
		chk_res(1'b1);
		check({31'h0, pin_out[8]}, 32'h1);
		pulse(0);
		expect_reg(`OFS_WORK, 32'h0000_0000);
		chk_res(1'b0);
		set_pin(2, 1'b1);
		pulse(0);
		expect_reg(`OFS_WORK, 32'h0000_ffff);
		chk_res(1'b1);
		pulse(1);
		expect_reg(`OFS_HOLD, 32'h0000_ffff);
		set_pin(2, 1'b0);
		// No gate and no strobe pin: level 0 with polarity 0 counts down
		start(updown_sample_mode, mk_sel(7'h00, 7'h00, 7'h01, 7'h09),
			5'h05, 16'h0010);
		pulse(0);
		pulse(1);
		expect_reg(`OFS_WORK, 32'h0000_000f);
		expect_reg(`OFS_HOLD, 32'h0000_0010);
		$display("test updown done");
	endtask : t_uds

	task automatic t_quad();
		// Result goes to a dummy pin only
		start(quadrature_mode, mk_sel(7'h00, 7'h02, 7'h01, 7'h31),
			5'h0f, 16'h0100);
		expect_reg(`OFS_WORK, 32'h0000_0100);
		expect_reg(`OFS_HOLD, 32'h0000_0010);
		set_pin(0, 1'b1);
		expect_reg(`OFS_WORK, 32'h0000_0101);
		set_pin(0, 1'b0);
		expect_reg(`OFS_WORK, 32'h0000_0100);
		set_pin(1, 1'b1);
		expect_reg(`OFS_WORK, 32'h0000_0101);
		set_pin(1, 1'b0);
		expect_reg(`OFS_WORK, 32'h0000_0100);
		$display("test quadrature done");
	endtask : t_quad

	task automatic t_frs_ins();
		start(freerun_sample_mode, mk_sel(7'h00, 7'h02, 7'h01, 7'h09),
			5'h05, 16'hffff);
		pulse(0);
		chk_res(1'b1);
		pulse(0);
		pulse(1);
		expect_reg(`OFS_WORK, 32'h0000_0001);
		expect_reg(`OFS_HOLD, 32'h0000_0001);
		chk_res(1'b1);
		start(freerun_sample_dn, mk_sel(7'h00, 7'h02, 7'h01, 7'h09),
			5'h05, 16'h0005);
		pulse(0);
		expect_reg(`OFS_WORK, 32'h0000_0004);
		start(interval_sample_mode, mk_sel(7'h00, 7'h02, 7'h01, 7'h09),
			5'h05, 16'h0003);
		pulse(0);
		pulse(1);
		expect_reg(`OFS_HOLD, 32'h0000_0004);
		expect_reg(`OFS_WORK, 32'h0000_0000);
		chk_res(1'b0);
		start(interval_sample_dn, mk_sel(7'h00, 7'h02, 7'h01, 7'h09),
			5'h05, 16'h0000);
		pulse(0);
		expect_reg(`OFS_WORK, 32'h0000_ffff);
		chk_res(1'b1);
		$display("test sample modes done");
	endtask : t_frs_ins

	task automatic t_frc();
		start(freerun_compare_mode, mk_sel(7'h00, 7'h00, 7'h01, 7'h09),
			5'h01, 16'h0002);
		pulse(0);
		expect_reg(`OFS_WORK, 32'h0000_0003);
		chk_res(1'b1);
		start(freerun_compare_dn, mk_sel(7'h00, 7'h00, 7'h01, 7'h09),
			5'h01, 16'h0005);
		// Start clears the output; the compare result follows one edge later
		repeat (2) @(posedge clk);
		chk_res(1'b1);
		pulse(0);
		expect_reg(`OFS_WORK, 32'h0000_0004);
		chk_res(1'b0);
		$display("test compare done");
	endtask : t_frc

	task automatic t_edges();
		// Falling edge only: the rise must leave the count alone
		start(freerun_sample_mode, mk_sel(7'h00, 7'h00, 7'h01, 7'h09),
			5'h02, 16'h0000);
		set_pin(0, 1'b1);
		expect_reg(`OFS_WORK, 32'h0000_0000);
		set_pin(0, 1'b0);
		expect_reg(`OFS_WORK, 32'h0000_0001);
		start(freerun_sample_mode, mk_sel(7'h00, 7'h00, 7'h01, 7'h09),
			5'h00, 16'h0000);
		pulse(0);
		expect_reg(`OFS_WORK, 32'h0000_0000);
		// Stopped channel holds its count
		start(freerun_sample_mode, mk_sel(7'h00, 7'h00, 7'h01, 7'h09),
			5'h01, 16'h0007);
		wr(`OFS_CTRL, 32'h0000_0008);
		pulse(0);
		expect_reg(`OFS_WORK, 32'h0000_0007);
		$display("test edges done");
	endtask : t_edges

	task automatic t_spaces();
		// Count selector 0: one step per clock until the stop write lands
		start(freerun_sample_mode, mk_sel(7'h00, 7'h00, 7'h00, 7'h09),
			5'h01, 16'h0000);
		wr(`OFS_CTRL, 32'h0000_0008);
		expect_reg(`OFS_WORK, 32'h0000_0003);
		// Hidden pin as count source, result routed to the first dummy pin
		start(freerun_sample_mode, mk_sel(7'h00, 7'h00, 7'h21, 7'h31),
			5'h01, 16'hffff);
		wr(`OFS_HIDDEN, 32'h0000_0001);
		wr(`OFS_HIDDEN, 32'h0000_0000);
		expect_reg(`OFS_WORK, 32'h0000_0000);
		expect_reg(`OFS_HIDDEN, 32'h0001_0000);
		expect_reg(`OFS_STATUS, 32'h0000_0001);
		// A driven fixed output reads back its own level
		wr(`OFS_PDATA, 32'h0000_0200);
		expect_reg(`OFS_LEVELS, 32'h0000_0200);
		$display("test pin spaces done");
	endtask : t_spaces

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_b      = 1'b0;
		hsel       = 1'b0;
		haddr      = 32'h0000_0000;
		htrans     = 2'b00;
		hwrite     = 1'b0;
		hwdata     = 32'h0000_0000;
		ext        = 32'h0000_0000;
		error_cnt  = 0;
		num_checks = 0;
		cyc        = 0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_uds();
		t_quad();
		t_frs_ins();
		t_frc();
		t_edges();
		t_spaces();
		wrap_up();
	end
endmodule : tb_multimode_pulse_counter
